// ---- hdl/cipc_core.v ----
// core interrupt, program counter, return stack and indirect addressing logic with apb access
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "cipc_regs.vh"

module cipc_core #(
    parameter STACK_DEPTH = 8,
    parameter PC_WIDTH    = 13
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        timer_overflow_evt,
    input  wire        ext_pin_evt,
    input  wire        port_change_evt,
    input  wire        comparator_out,
    input  wire [1:0]  rst_cause,
    input  wire        brownout_circuit_enable,
    output reg  [8:0]  mem_addr,
    output reg  [7:0]  mem_wdata,
    output reg         mem_we,
    input  wire [7:0]  mem_rdata,
    output reg  [12:0] pc_value,
    output reg         irq_request
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    reg  [3:0]          sync1_q;
    reg  [3:0]          sync2_q;
    reg  [3:0]          sync3_q;
    reg  [3:0]          filt_q;
    reg  [2:0]          fill_q;
    wire [3:0]          filt_d;
    wire [3:0]          rise;
    wire                cmp_change;
    reg                 global_irq_enable_q;
    reg                 periph_irq_enable_q;
    reg                 timer_overflow_irq_enable_q;
    reg                 ext_pin_irq_enable_q;
    reg                 port_change_irq_enable_q;
    reg                 timer_overflow_flag_q;
    reg                 ext_pin_irq_flag_q;
    reg                 port_change_flag_q;
    reg                 comparator_irq_enable_q;
    reg                 comparator_irq_flag_q;
    reg                 por_status_q;
    reg                 brownout_status_q;
    reg  [1:0]          cause_q;
    reg                 captured_q;
    reg  [4:0]          pc_upper_latch_q;
    reg  [7:0]          file_select_pointer_q;
    reg  [PC_WIDTH-1:0] pc_q;
    reg  [PC_WIDTH-1:0] pc_d;
    reg  [PC_WIDTH-1:0] stack_q [0:STACK_DEPTH-1];
    reg  [2:0]          sp_q;
    reg  [2:0]          sp_d;
    reg                 push;
    reg  [PC_WIDTH-1:0] push_val;
    reg                 gie_set;
    reg                 gie_clr;
    wire [9:0]          idx;
    wire                aligned;
    wire                setup;
    wire                acc_done;
    wire                wr;
    wire                irq_pend;
    wire [2:0]          cmd_op;
    wire [10:0]         cmd_tgt;
    wire                ind_self;
    wire [2:0]          sp_top;
    reg  [31:0]         rd_d;
    reg                 hit;
    integer             i;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode
    assign idx      = paddr[11:2];
    assign aligned  = (paddr[1:0] == 2'h0);
    assign setup    = psel & ~penable;
    assign acc_done = psel & penable & pready;
    assign wr       = acc_done & pwrite & hit;
    assign cmd_op   = pwdata[`CIPC_CMD_OP_LSB+2:`CIPC_CMD_OP_LSB];
    assign cmd_tgt  = pwdata[10:0];
    // pointer naming the port itself in either bank
    assign ind_self = (file_select_pointer_q[6:0] == 7'h00);
    assign sp_top   = sp_q - 3'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // event inputs: three-stage synchroniser, level moves when stages two and three agree
    assign filt_d     = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
    // a pin already high at reset release is a level, not an event
    assign rise       = {4{fill_q == `CIPC_SYNC_FILL}} & filt_d & ~filt_q;
    assign cmp_change = (fill_q == `CIPC_SYNC_FILL) & (filt_d[3] ^ filt_q[3]);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            filt_q  <= 4'h0;
            fill_q  <= 3'h0;
        end
        else
        begin
            if (fill_q != `CIPC_SYNC_FILL)
                fill_q <= fill_q + 3'h1;
            sync1_q <= {comparator_out, port_change_evt, ext_pin_evt, timer_overflow_evt};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt qualification
    assign irq_pend = global_irq_enable_q & (
        (timer_overflow_irq_enable_q & timer_overflow_flag_q) |
        (ext_pin_irq_enable_q & ext_pin_irq_flag_q) |
        (port_change_irq_enable_q & port_change_flag_q) |
        (periph_irq_enable_q & comparator_irq_enable_q & comparator_irq_flag_q));

    ////////////////////////////////////////////////////////////////////////////////
    // read mux
    always @*
    begin
        rd_d = 32'h0000_0000;
        hit  = aligned;
        case (idx)
            `CIPC_IDX_INTCTL:
                rd_d[7:0] = {global_irq_enable_q, periph_irq_enable_q, timer_overflow_irq_enable_q,
                             ext_pin_irq_enable_q, port_change_irq_enable_q, timer_overflow_flag_q,
                             ext_pin_irq_flag_q, port_change_flag_q};
            `CIPC_IDX_PFLAGS:
                rd_d[`CIPC_CMP_BIT] = comparator_irq_flag_q;
            `CIPC_IDX_PENABLES:
                rd_d[`CIPC_CMP_BIT] = comparator_irq_enable_q;
            `CIPC_IDX_PWRSTAT:
                rd_d[1:0] = {por_status_q, brownout_status_q};
            `CIPC_IDX_PC_LOW:
                rd_d[7:0] = pc_q[7:0];
            `CIPC_IDX_PC_UPPER:
                rd_d[4:0] = pc_upper_latch_q;
            `CIPC_IDX_FSEL:
                rd_d[7:0] = file_select_pointer_q;
            `CIPC_IDX_INDIRECT:
                rd_d[7:0] = ind_self ? 8'h00 : mem_rdata;
            `CIPC_IDX_CMD:
                rd_d = 32'h0000_0000;
            `CIPC_IDX_CORESTAT:
                rd_d = {14'h0000, cause_q, 3'h0, pc_q};
            default:
                hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer on the second access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            mem_addr  <= 9'h000;
            mem_wdata <= 8'h00;
            mem_we    <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & penable & ~pready)
                prdata <= pwrite ? 32'h0000_0000 : rd_d;
            if (setup)
            begin
                mem_addr <= {1'b0, file_select_pointer_q};
            end
            mem_we <= 1'b0;
            if (wr && idx == `CIPC_IDX_INDIRECT && !ind_self)
            begin
                mem_we    <= 1'b1;
                mem_wdata <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt enables and flags; a hardware set wins over a software clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {global_irq_enable_q, periph_irq_enable_q, timer_overflow_irq_enable_q,
             ext_pin_irq_enable_q, port_change_irq_enable_q, timer_overflow_flag_q,
             ext_pin_irq_flag_q, port_change_flag_q} <= `CIPC_INTCTL_RST;
            comparator_irq_enable_q <= `CIPC_PENABLES_RST;
            comparator_irq_flag_q   <= `CIPC_PFLAGS_RST;
            irq_request             <= 1'b0;
        end
        else
        begin
            if (wr && idx == `CIPC_IDX_INTCTL)
            begin
                global_irq_enable_q         <= pwdata[`CIPC_GIE_BIT];
                periph_irq_enable_q         <= pwdata[`CIPC_PERIPH_IRQ_ENABLE_BIT];
                timer_overflow_irq_enable_q <= pwdata[`CIPC_TIMER_OVERFLOW_IRQ_ENABLE_BIT];
                ext_pin_irq_enable_q        <= pwdata[`CIPC_INTE_BIT];
                port_change_irq_enable_q    <= pwdata[`CIPC_PORT_CHANGE_IRQ_ENABLE_BIT];
            end
            else if (gie_clr)
                global_irq_enable_q <= 1'b0;
            else if (gie_set)
                global_irq_enable_q <= 1'b1;
            timer_overflow_flag_q <= rise[0] |
                ((wr && idx == `CIPC_IDX_INTCTL) ? pwdata[`CIPC_TIMER_OVERFLOW_FLAG_BIT] : timer_overflow_flag_q);
            ext_pin_irq_flag_q <= rise[1] |
                ((wr && idx == `CIPC_IDX_INTCTL) ? pwdata[`CIPC_EXT_PIN_IRQ_FLAG_BIT] : ext_pin_irq_flag_q);
            port_change_flag_q <= rise[2] |
                ((wr && idx == `CIPC_IDX_INTCTL) ? pwdata[`CIPC_PORT_CHANGE_FLAG_BIT] : port_change_flag_q);
            if (wr && idx == `CIPC_IDX_PENABLES)
                comparator_irq_enable_q <= pwdata[`CIPC_CMP_BIT];
            comparator_irq_flag_q <= cmp_change |
                ((wr && idx == `CIPC_IDX_PFLAGS) ? pwdata[`CIPC_CMP_BIT] : comparator_irq_flag_q);
            irq_request <= irq_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset cause capture; these bits survive reset so software can compare
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            captured_q <= 1'b0;
        else
            captured_q <= 1'b1;
    end

    always @(posedge pclk)
    begin
        if (!captured_q && presetn)
        begin
            cause_q <= rst_cause;
            if (rst_cause == `CIPC_CAUSE_POR)
            begin
                por_status_q      <= 1'b0;
                brownout_status_q <= 1'b0;
            end
            else if (rst_cause == `CIPC_CAUSE_BOR && brownout_circuit_enable)
                brownout_status_q <= 1'b0;
        end
        else if (wr && idx == `CIPC_IDX_PWRSTAT)
        begin
            por_status_q      <= pwdata[`CIPC_POR_BIT];
            brownout_status_q <= pwdata[`CIPC_BOD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // program counter and return stack control
    always @*
    begin
        pc_d     = pc_q;
        sp_d     = sp_q;
        push     = 1'b0;
        push_val = pc_q;
        gie_set  = 1'b0;
        gie_clr  = 1'b0;
        if (wr && idx == `CIPC_IDX_PC_LOW)
            pc_d = {pc_upper_latch_q, pwdata[7:0]};
        else if (wr && idx == `CIPC_IDX_CMD)
        begin
            case (cmd_op)
                `CIPC_OP_STEP:
                    pc_d = pc_q + 13'h0001;
                `CIPC_OP_CALL:
                begin
                    push     = 1'b1;
                    push_val = pc_q + 13'h0001;
                    pc_d     = {pc_upper_latch_q[4:3], cmd_tgt};
                end
                `CIPC_OP_JUMP:
                    pc_d = {pc_upper_latch_q[4:3], cmd_tgt};
                `CIPC_OP_RETURN, `CIPC_OP_RETLIT, `CIPC_OP_RETIRQ:
                begin
                    pc_d    = stack_q[sp_top];
                    sp_d    = sp_top;
                    gie_set = (cmd_op == `CIPC_OP_RETIRQ);
                end
                `CIPC_OP_TAKE_IRQ:
                    if (irq_pend)
                    begin
                        push    = 1'b1;
                        pc_d    = `CIPC_IRQ_VECTOR;
                        gie_clr = 1'b1;
                    end
                default:
                    pc_d = pc_q;
            endcase
        end
        if (push)
            sp_d = sp_q + 3'h1;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_q                  <= `CIPC_PC_RST;
            pc_value              <= `CIPC_PC_RST;
            sp_q                  <= 3'h0;
            pc_upper_latch_q      <= `CIPC_PC_UPPER_RST;
            file_select_pointer_q <= `CIPC_FSEL_RST;
        end
        else
        begin
            pc_q     <= pc_d;
            pc_value <= pc_d;
            sp_q     <= sp_d;
            // the stack path never touches the upper latch
            if (wr && idx == `CIPC_IDX_PC_UPPER)
                pc_upper_latch_q <= pwdata[4:0];
            if (wr && idx == `CIPC_IDX_FSEL)
                file_select_pointer_q <= pwdata[7:0];
        end
    end

    // stack storage; the oldest entry is overwritten after eight pushes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (i = 0; i < STACK_DEPTH; i = i + 1)
                stack_q[i] <= `CIPC_PC_RST;
        end
        else if (push)
            stack_q[sp_q] <= push_val;
    end

endmodule // cipc_core

// ---- hdl/cipc_regs.vh ----
// register indices, field positions, reset values and command codes of the core block
`ifndef CIPC_REGS_VH
`define CIPC_REGS_VH

// register indices; byte address is four times the index
`define CIPC_IDX_INDIRECT     10'h000
`define CIPC_IDX_PC_LOW       10'h002
`define CIPC_IDX_FSEL         10'h004
`define CIPC_IDX_PC_UPPER     10'h00a
`define CIPC_IDX_INTCTL       10'h00b
`define CIPC_IDX_PFLAGS       10'h00c
`define CIPC_IDX_PENABLES     10'h08c
`define CIPC_IDX_PWRSTAT      10'h08e
`define CIPC_IDX_CMD          10'h040
`define CIPC_IDX_CORESTAT     10'h041

// interrupt_control fields
`define CIPC_GIE_BIT          7
`define CIPC_PERIPH_IRQ_ENABLE_BIT         6
`define CIPC_TIMER_OVERFLOW_IRQ_ENABLE_BIT         5
`define CIPC_INTE_BIT         4
`define CIPC_PORT_CHANGE_IRQ_ENABLE_BIT         3
`define CIPC_TIMER_OVERFLOW_FLAG_BIT         2
`define CIPC_EXT_PIN_IRQ_FLAG_BIT         1
`define CIPC_PORT_CHANGE_FLAG_BIT         0

// peripheral enable / flag field
`define CIPC_CMP_BIT          6

// power_reset_status fields
`define CIPC_POR_BIT          1
`define CIPC_BOD_BIT          0

// reset values
`define CIPC_INTCTL_RST       8'h00
`define CIPC_PENABLES_RST     1'b0
`define CIPC_PFLAGS_RST       1'b0
`define CIPC_PC_RST           13'h0000
`define CIPC_PC_UPPER_RST     5'h00
`define CIPC_FSEL_RST         8'h00

// reset cause codes on rst_cause
`define CIPC_CAUSE_POR        2'h0
`define CIPC_CAUSE_EXT        2'h1
`define CIPC_CAUSE_WDT        2'h2
`define CIPC_CAUSE_BOR        2'h3

// command register: opcode in bits 18:16, target in bits 10:0
`define CIPC_CMD_OP_LSB       16
`define CIPC_OP_STEP          3'h1
`define CIPC_OP_CALL          3'h2
`define CIPC_OP_JUMP          3'h3
`define CIPC_OP_RETURN        3'h4
`define CIPC_OP_RETLIT        3'h5
`define CIPC_OP_RETIRQ        3'h6
`define CIPC_OP_TAKE_IRQ      3'h7

// interrupt vector location
`define CIPC_IRQ_VECTOR       13'h0004

// synchroniser fill cycles after reset before input edges count
`define CIPC_SYNC_FILL        3'h4

`endif

// ---- verif/cipc_core_asserts.sv ----
// concurrent checks on the bus, indirect write and interrupt request ports of the core block
`timescale 1ns/1ps
module cipc_core_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        mem_we,
    input wire [12:0] pc_value,
    input wire        irq_request
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_answer_timing: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("bus answer not in second access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_error_data: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("error response without ready or with data");
    a_unmapped_error: assert property (pready && paddr == 12'h004 |-> pslverr)
        else $error("unmapped index answered without error");
    a_reserved_zero: assert property (pready && !pwrite && (paddr == 12'h030 || paddr == 12'h230)
        |-> prdata[31:7] == 25'h0 && prdata[5:0] == 6'h0)
        else $error("unimplemented peripheral bits read nonzero");
    a_indirect_we: assert property (mem_we |-> $past(pready) && $past(pwrite) && $past(paddr) == 12'h000)
        else $error("memory write without indirect port write");
    a_we_single: assert property (mem_we |=> !mem_we)
        else $error("memory write strobe longer than one cycle");
    a_reset_pc: assert property ($rose(presetn) |-> pc_value == 13'h0000)
        else $error("program counter not zero after reset");
    a_gie_blocks: assert property (pready && pwrite && paddr == 12'h02c && !pwdata[7] |-> ##2 !irq_request)
        else $error("interrupt request with global enable clear");
endmodule // cipc_core_asserts

bind cipc_core cipc_core_asserts u_cipc_core_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_we(mem_we), .pc_value(pc_value), .irq_request(irq_request));

// ---- verif/cipc_core_tb.sv ----
// self-checking testbench of the core interrupt, program counter, stack and indirect block
`timescale 1ns/1ps
`include "cipc_regs.vh"
module cipc_core_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_we, irq_request;
    logic        timer_overflow_evt, ext_pin_evt, port_change_evt, comparator_out, bod_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  rst_cause, rd_cause;
    logic [8:0]  mem_addr, we_addr;
    logic [7:0]  mem_wdata, we_data;
    logic [12:0] pc_value;
    wire  [7:0]  mem_rdata;
    int          n_errors, cmp_count, we_cnt, i;

    cipc_core u_cipc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_overflow_evt(timer_overflow_evt), .ext_pin_evt(ext_pin_evt), .port_change_evt(port_change_evt),
        .comparator_out(comparator_out), .rst_cause(rst_cause), .brownout_circuit_enable(bod_en),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
        .pc_value(pc_value), .irq_request(irq_request));

    // data memory answers with a pattern derived from the address
    assign mem_rdata = mem_addr[7:0] ^ 8'h5a;

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk)
        if (mem_we === 1'b1)
        begin
            we_cnt <= we_cnt + 1;
            we_addr <= mem_addr;
            we_data <= mem_wdata;
        end
    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd, input logic exp_err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 20)
        begin
            n_errors++;
            conclude();
        end
        rd = prdata;
        check({31'h0, pslverr}, {31'h0, exp_err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr_reg(input logic [9:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, 1'b0);
    endtask

    task rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, 1'b0);
        check(rd, exp);
    endtask

    task pc_chk(input logic [12:0] exp);
        rd_chk(`CIPC_IDX_CORESTAT, {14'h0, rd_cause, 3'h0, exp});
        check({19'h0, pc_value}, {19'h0, exp});
    endtask

    task cmd(input logic [2:0] op, input logic [10:0] tgt);
        wr_reg(`CIPC_IDX_CMD, {13'h0, op, 5'h0, tgt});
    endtask

    task irq_chk(input logic exp);
        int n;
        repeat (3) @(posedge pclk);
        n = 0;
        while (irq_request !== exp && n < 10)
        begin
            n++;
            @(posedge pclk);
        end
        check({31'h0, irq_request}, {31'h0, exp});
    endtask

    task do_reset(input logic [1:0] cause);
        @(posedge pclk);
        presetn <= 1'b0;
        rst_cause <= cause;
        rd_cause = cause;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset_values;
        rd_chk(`CIPC_IDX_INTCTL, 32'h0);
        rd_chk(`CIPC_IDX_PFLAGS, 32'h0);
        rd_chk(`CIPC_IDX_PWRSTAT, 32'h0);
        pc_chk(13'h0000);
        wr_reg(`CIPC_IDX_PENABLES, 32'hffff_ffff);
        rd_chk(`CIPC_IDX_PENABLES, 32'h40);
        wr_reg(`CIPC_IDX_PENABLES, 32'h0);
        apb(1'b0, 10'h001, 32'h0, 1'b1);
        check(rd, 32'h0);
        $display("test reset_values done");
    endtask

    task t_flags_and_irq;
        @(posedge pclk);
        timer_overflow_evt <= 1'b1;
        ext_pin_evt <= 1'b1;
        port_change_evt <= 1'b1;
        comparator_out <= ~comparator_out;
        repeat (2) @(posedge pclk);
        timer_overflow_evt <= 1'b0;
        ext_pin_evt <= 1'b0;
        port_change_evt <= 1'b0;
        repeat (8) @(posedge pclk);
        rd_chk(`CIPC_IDX_INTCTL, 32'h07);
        rd_chk(`CIPC_IDX_PFLAGS, 32'h40);
        irq_chk(1'b0);
        wr_reg(`CIPC_IDX_INTCTL, 32'h27);
        irq_chk(1'b0);
        wr_reg(`CIPC_IDX_INTCTL, 32'ha7);
        irq_chk(1'b1);
        wr_reg(`CIPC_IDX_INTCTL, 32'h87);
        irq_chk(1'b0);
        wr_reg(`CIPC_IDX_PENABLES, 32'h40);
        wr_reg(`CIPC_IDX_INTCTL, 32'h80);
        irq_chk(1'b0);
        wr_reg(`CIPC_IDX_INTCTL, 32'hc0);
        irq_chk(1'b1);
        wr_reg(`CIPC_IDX_PENABLES, 32'h0);
        irq_chk(1'b0);
        wr_reg(`CIPC_IDX_PFLAGS, 32'h0);
        wr_reg(`CIPC_IDX_INTCTL, 32'h0);
        rd_chk(`CIPC_IDX_PFLAGS, 32'h0);
        $display("test flags_and_irq done");
    endtask

    task t_pc_load;
        wr_reg(`CIPC_IDX_PC_UPPER, 32'h1f);
        wr_reg(`CIPC_IDX_PC_LOW, 32'h34);
        pc_chk(13'h1f34);
        rd_chk(`CIPC_IDX_PC_LOW, 32'h34);
        cmd(`CIPC_OP_JUMP, 11'h123);
        pc_chk(13'h1923);
        cmd(`CIPC_OP_STEP, 11'h0);
        pc_chk(13'h1924);
        $display("test pc_load done");
    endtask

    task t_stack_wrap;
        wr_reg(`CIPC_IDX_PC_UPPER, 32'h05);
        cmd(`CIPC_OP_JUMP, 11'h000);
        for (i = 1; i <= 9; i++)
            cmd(`CIPC_OP_CALL, i * 16);
        pc_chk(13'h0090);
        for (i = 9; i >= 2; i--)
        begin
            cmd(3'h4 + i % 3, 11'h0);
            pc_chk((i - 1) * 16 + 1);
        end
        cmd(`CIPC_OP_RETURN, 11'h0);
        pc_chk(13'h0081);
        rd_chk(`CIPC_IDX_PC_UPPER, 32'h05);
        wr_reg(`CIPC_IDX_INTCTL, 32'ha4);
        irq_chk(1'b1);
        cmd(`CIPC_OP_TAKE_IRQ, 11'h0);
        pc_chk(`CIPC_IRQ_VECTOR);
        rd_chk(`CIPC_IDX_INTCTL, 32'h24);
        cmd(`CIPC_OP_RETIRQ, 11'h0);
        pc_chk(13'h0081);
        rd_chk(`CIPC_IDX_INTCTL, 32'ha4);
        wr_reg(`CIPC_IDX_INTCTL, 32'h0);
        $display("test stack_wrap done");
    endtask

    task t_indirect;
        int base;
        base = we_cnt;
        wr_reg(`CIPC_IDX_FSEL, 32'h25);
        wr_reg(`CIPC_IDX_INDIRECT, 32'ha5);
        repeat (2) @(posedge pclk);
        check(we_cnt - base, 1);
        check({23'h0, we_addr}, 32'h025);
        check({24'h0, we_data}, 32'ha5);
        rd_chk(`CIPC_IDX_INDIRECT, 32'h25 ^ 32'h5a);
        wr_reg(`CIPC_IDX_FSEL, 32'h80);
        rd_chk(`CIPC_IDX_FSEL, 32'h80);
        wr_reg(`CIPC_IDX_INDIRECT, 32'h11);
        repeat (2) @(posedge pclk);
        check(we_cnt - base, 1);
        rd_chk(`CIPC_IDX_INDIRECT, 32'h0);
        $display("test indirect done");
    endtask

    task t_brownout;
        wr_reg(`CIPC_IDX_PWRSTAT, 32'h03);
        rd_chk(`CIPC_IDX_PWRSTAT, 32'h03);
        do_reset(`CIPC_CAUSE_BOR);
        rd_chk(`CIPC_IDX_PWRSTAT, 32'h02);
        pc_chk(13'h0000);
        rd_chk(`CIPC_IDX_PFLAGS, 32'h0);
        wr_reg(`CIPC_IDX_PWRSTAT, 32'h03);
        do_reset(`CIPC_CAUSE_WDT);
        rd_chk(`CIPC_IDX_PWRSTAT, 32'h03);
        pc_chk(13'h0000);
        bod_en <= 1'b0;
        do_reset(`CIPC_CAUSE_BOR);
        rd_chk(`CIPC_IDX_PWRSTAT, 32'h03);
        pc_chk(13'h0000);
        bod_en <= 1'b1;
        $display("test brownout done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, presetn} = 4'h0;
        {timer_overflow_evt, ext_pin_evt, port_change_evt, comparator_out} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rst_cause = `CIPC_CAUSE_POR;
        bod_en = 1'b1;
        {n_errors, cmp_count, we_cnt} = 0;
        do_reset(`CIPC_CAUSE_POR);
        t_reset_values();
        t_flags_and_irq();
        t_pc_load();
        t_stack_wrap();
        t_indirect();
        t_brownout();
        conclude();
    end

    initial
    begin
        #2000000;
        n_errors++;
        conclude();
    end
endmodule // cipc_core_tb
